//--- gpio_regulator_control_tb.sv
`timescale 1ns/1ps
module gpio_regulator_control_tb;
  import grc_pkg::*;
  // ==========
  // Stimulus and model state
  logic clk = 1'b0;
  logic resetn = 1'b0;
  grc_apb_req_t req = '0;
  logic pready, pslverr, wk, wc, wh, srr, rlr, mss, tro, sl, fl;
  logic [31:0] prdata, rd;
  logic [4:0] pin_in = '0, pout, poe, pp, spl = '0, m;
  logic [5:0] cmd = '0;
  logic [3:0] ilim, ov;
  logic sclk = 1'b0, scen = 1'b0;
  logic pdm = 1'b0, am = 1'b1;
  logic [15:0] lf = 16'hF8DC;
  grc_reg_out_t ro;
  int fails = 0, tests_run = 0, n;
  int mdl [int];
  grc_far_model grc_far_model_i (.clk(clk), .cmd(cmd), .supply_low(sl), .ldo_ilim(ilim), .ldo_overvolt(ov));
  // Shortened limit timers keep the run brief
  grc_top #(.LIM_EVENT_CYCLES(20), .LIM_SHUT_CYCLES(50)) grc_top_i (.clk(clk), .resetn(resetn),
    .apb_req(req), .pready(pready), .prdata(prdata), .pslverr(pslverr), .pin_in(pin_in), .pin_out(pout),
    .pin_oe(poe), .pin_pull_select(pp), .memory_supply_sense(mss), .termination_reference_output(tro),
    .supply_low(sl), .slow_clock_in(sclk), .seq_pin_level(spl), .seq_clk_en(scen), .seq_reg_en(4'h0),
    .seq_reg_sel(8'h00), .power_down_mode(pdm), .reset_mode(1'b0), .active_mode(am), .ldo_ilim(ilim),
    .ldo_overvolt(ov), .system_run_request(srr), .run_level_request(rlr), .wakeup_event(wk),
    .watchdog_clear(wc), .watchdog_hold(wh), .reg_out(ro));
  always #5 clk = ~clk;
  function automatic logic [15:0] lfsr_next(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : lfsr_next
  // Sequencer inputs wander randomly; one scenario follows them on pin 3
  always @(posedge clk) begin
    lf <= lfsr_next(lf);
    {scen, spl, sclk} <= lf[6:0];
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish
  // One APB transfer; answer is taken while pready stands high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk) req <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk) req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    fl = pslverr;
    if (pready !== 1'b1) chk(0, 1);
    if (pready !== 1'b1) tally_and_finish();
    req <= '0;
    if (w) mdl[a] = d;
  endtask : apb
  // ==========
  // Scenarios
  initial begin
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    apb(0, OFS_MISC, 0); chk(rd, MISC_RST);
    apb(0, OFS_EVENT, 0); chk(rd, 0);
    apb(0, 8'h1C, 0); chk(fl, 1);
    for (int i = 0; i < 4; i++) begin
      m = lf[4:0];
      apb(1, OFS_PIN_CFG, {17'h0, m, 10'h3FF});
      repeat (2) @(negedge clk);
      chk(pout, mdl[OFS_PIN_CFG][14:10]);
      chk(poe, 5'h1F);
      apb(1, OFS_PIN_CFG, {12'h0, lf[9:5], m, 10'h2AA});
      repeat (2) @(negedge clk);
      chk({pp, poe}, {mdl[OFS_PIN_CFG][19:15], ~m});
    end
    apb(1, OFS_PIN_CFG, {17'h0, m, 10'h3FF});
    apb(1, OFS_OUT_SEL, 32'h800);
    for (int f = 0; f < 2; f++) begin
      @(posedge clk) cmd <= 6'(f);
      repeat (8) @(negedge clk);
      chk(pout[3], {~f[0] ^ m[3]});
    end
    // Pin 1 forwards debounced pin 2; pin 3 follows the sequencer one cycle late
    apb(1, OFS_OUT_SEL, 32'h0008_0408);
    @(posedge clk) pin_in <= 5'h04;
    repeat (8) @(negedge clk) m = spl;
    @(negedge clk) chk({pout[3], pout[1]}, {m[3], 1'b1});
    @(posedge clk) pin_in <= '0;
    apb(1, OFS_OUT_SEL, 32'h600);
    apb(1, OFS_MISC, 32'h23);
    @(posedge clk) pdm <= 1'b1;
    repeat (2) @(negedge clk);
    for (int i = 0; i < 8; i++) @(negedge clk) chk(pout[3], 0);
    @(posedge clk) pdm <= 1'b0;
    apb(1, OFS_MISC, 32'h2C);
    repeat (2) @(negedge clk);
    chk({poe[1:0], pout[1:0], mss, tro}, 6'h03);
    $display("test pins done");
    apb(1, OFS_MISC, 32'h20);
    apb(1, OFS_REG_CTRL, 32'h1);
    repeat (2) @(negedge clk);
    chk(ro.ldo_enable[0], 1);
    @(posedge clk) cmd <= 6'h02;
    repeat (8) @(posedge clk);
    apb(0, OFS_EVENT, 0); chk(rd[EV_LIM], 0);
    repeat (30) @(posedge clk);
    apb(0, OFS_EVENT, 0); chk(rd[EV_LIM], 1);
    apb(0, OFS_STATUS, 0); chk(rd[ST_ILIM_LSB], 1);
    repeat (40) @(negedge clk);
    chk(ro.ldo_enable[0], 0);
    @(posedge clk) cmd <= 6'h00;
    apb(1, OFS_REG_CTRL, 32'h1);
    repeat (2) @(negedge clk);
    chk(ro.ldo_enable[0], 1);
    // Setting B with sleep link, then an over-voltage on the first regulator
    apb(1, 8'h20, 32'h0002_1205);
    apb(1, OFS_REG_CTRL, 32'h101);
    @(posedge clk) cmd <= 6'h04;
    repeat (8) @(negedge clk);
    chk({ro.voltage[0], ro.ldo_sleep[0], ro.ldo_discharge[0]}, {7'h12, 2'b11});
    @(posedge clk) am <= 1'b0;
    apb(1, 8'h30, 32'h1_0055);
    apb(0, 8'h30, 0); chk(rd, 0);
    @(posedge clk) am <= 1'b1;
    apb(1, 8'h30, 32'h1_0055);
    apb(0, 8'h30, 0); chk(rd, 32'h1_0055);
    chk({ro.voltage[4], ro.buck_sleep[4]}, {7'h55, 1'b1});
    $display("test limit done");
    apb(1, OFS_MISC, 32'h30);
    apb(1, OFS_PIN_CFG, 32'h0140_0000);
    @(posedge clk) pin_in <= 5'h15;
    for (n = 0; n < 40 && wk !== 1'b1; n++) @(negedge clk);
    chk({wk, srr, rlr, wh}, 4'hE);
    apb(0, OFS_EVENT, 0); chk(rd[4], 1);
    @(posedge clk) pin_in <= 5'h14;
    for (n = 0; n < 40 && wc !== 1'b1; n++) @(negedge clk);
    chk({wc, wh}, 2'b11);
    $display("test alternate done");
    tally_and_finish();
  end
endmodule : gpio_regulator_control_tb

//--- grc_far_model.sv
`timescale 1ns/1ps
// Far side: supply monitor and regulator comparators, one flop late
module grc_far_model (
  input wire logic clk,
  input wire logic [5:0] cmd,
  output logic supply_low,
  output logic [3:0] ldo_ilim,
  output logic [3:0] ldo_overvolt
);
  // Comparator levels follow the bench command word
  always_ff @(posedge clk) begin
    supply_low <= cmd[0];
    ldo_ilim <= {3'h0, cmd[1]};
    ldo_overvolt <= cmd[5:2];
  end
endmodule : grc_far_model

//--- grc_pkg.sv
// Operation
// - Output pins drive push-pull or open drain; open drain has a switchable pull-up.
// - Output with selector zero drives the pin mode bit: 0 low, 1 high.
// - Selector 1 to 4 picks forwarded input, sequencer level, slow clock or supply fault; 5 to 7 drive the mode bit.
// - Supply fault status asserts while the system supply is below its upper threshold.
// - Routed supply fault is inverted by the mode bit; driver and pull act normally.
// - Slow clock buffer enabled by sequencer or manual bit; pause stops it in power-down.
// - Alternate inputs on pins 0, 2, 4 use only the input buffer, optional debounce.
// - System enable on pin 4 drives run request; assertion gives event and wake-up.
// - Power enable on pin 2 drives run-level request; wakes only if enabled.
// - Watchdog kick active edge clears counter; held asserted it stops the counter.
// - Debounced pins 0 to 3 forward to output pins 0, 1 or 3.
// - Pins taken for analog termination use lose every digital function.
// - Converter voltage writes accepted only while in active power mode.
// - Each regulator holds settings A and B with voltage and sleep bit; select chooses.
// - A/B selection by software, sequencer or input pin; enable by another pin.
// - Linear regulator enabled by direct write, assigned input pin or sequencer step.
// - Sleep link bit for A or B puts the regulator to sleep when active.
// - First linear regulator may be always-on and stays enabled in reset mode.
// - Over current beyond 10 ms raises limit event; raw comparator readable.
// - Over current beyond 200 ms clears enable unless shutdown control is clear.
// - Over-voltage switches on discharge load unless pull-down disable is set.
// - Function code: 0 alternate, 1 input, 2 open drain, 3 push-pull.
// - Assigned pin sets enable on active edge and clears it on passive edge.
package grc_pkg;
  // ==========================================================================
  // Sizes
  localparam int NPIN = 5;
  localparam int NLDO = 4;
  localparam int NREG = 8;
  localparam int FN_W = 2;
  localparam int OS_W = 3;
  localparam int FWD_W = 2;
  localparam int SRC_W = 2;
  localparam int V_W = 7;
  localparam int SET_W = 19;
  localparam int DEB_W = 10;
  localparam int CNT_W = 25;
  localparam int ASYNC_W = NPIN + 2 + 2 * NLDO;
  // ==========================================================================
  // Register offsets (byte addresses)
  localparam logic [7:0] OFS_PIN_CFG = 8'h00;
  localparam logic [7:0] OFS_OUT_SEL = 8'h04;
  localparam logic [7:0] OFS_MISC = 8'h08;
  localparam logic [7:0] OFS_REG_CTRL = 8'h0C;
  localparam logic [7:0] OFS_GPI_ASSIGN = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_EVENT = 8'h18;
  localparam logic [2:0] SET_PAGE = 3'h1;
  // ==========================================================================
  // Field positions
  localparam int PC_FUNC_LSB = 0;
  localparam int PC_MODE_LSB = 10;
  localparam int PC_PULL_LSB = 15;
  localparam int PC_POL_LSB = 20;
  localparam int PC_DEB_LSB = 25;
  localparam int OS_SRC_LSB = 0;
  localparam int OS_FWD_LSB = 16;
  localparam int MI_CLK_EN = 0;
  localparam int MI_PAUSE = 1;
  localparam int MI_TERM_MODE = 2;
  localparam int MI_TERM_REF = 3;
  localparam int MI_WAKE2 = 4;
  localparam int MI_SHUT_EN = 5;
  localparam int MI_ALWAYS_ON = 6;
  localparam int RC_EN_LSB = 0;
  localparam int RC_SEL_LSB = 8;
  localparam int GA_SEL_LSB = 0;
  localparam int GA_EN_LSB = 16;
  localparam int ST_PIN_LSB = 0;
  localparam int ST_ILIM_LSB = 8;
  localparam int ST_SYS_RUN = 16;
  localparam int ST_RUN_LVL = 17;
  localparam int ST_FAULT = 18;
  localparam int ST_WD_HOLD = 19;
  localparam int EV_PIN_LSB = 0;
  localparam int EV_LIM = 8;
  localparam int EV_W = 9;
  localparam int SE_VA_LSB = 0;
  localparam int SE_VB_LSB = 8;
  localparam int SE_SLA = 16;
  localparam int SE_SLB = 17;
  localparam int SE_PDD = 18;
  localparam int PIN_WDK = 0;
  localparam int PIN_PWR = 2;
  localparam int PIN_SYS = 4;
  localparam logic [NPIN-1:0] FWD_PINS = 5'h0B;
  // ==========================================================================
  // Reset values
  localparam logic [31:0] PIN_CFG_RST = 32'h0000_0000;
  localparam logic [31:0] OUT_SEL_RST = 32'h0000_0000;
  localparam logic [31:0] MISC_RST = 32'h0000_0020;
  localparam logic [31:0] GPI_RST = 32'h0000_0000;
  localparam logic [SET_W-1:0] SET_RST = 19'h0_0000;
  // ==========================================================================
  // Timing
  localparam int CLK_HZ = 100_000_000;
  localparam int DEB_US = 10;
  localparam int LIM_EVENT_MS = 10;
  localparam int LIM_SHUT_MS = 200;
  localparam int DEB_CYC = DEB_US * (CLK_HZ / 1_000_000);
  localparam int LIM_EVENT_CYC = LIM_EVENT_MS * (CLK_HZ / 1000);
  localparam int LIM_SHUT_CYC = LIM_SHUT_MS * (CLK_HZ / 1000);
  // ==========================================================================
  // Types
  typedef enum logic [FN_W-1:0] {FN_ALT, FN_IN, FN_OD, FN_PP} grc_func_t;
  typedef enum logic [OS_W-1:0] {SRC_MODE, SRC_FWD, SRC_SEQ, SRC_CLK, SRC_FAULT} grc_out_src_t;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } grc_apb_req_t;
  typedef struct packed {
    logic [NLDO-1:0] ldo_enable;
    logic [NLDO-1:0] ldo_sleep;
    logic [NLDO-1:0] ldo_discharge;
    logic [NREG-1:0][V_W-1:0] voltage;
    logic [NREG-1:NLDO] buck_sleep;
  } grc_reg_out_t;
endpackage : grc_pkg

//--- grc_top.sv
// Design decisions made here: the APB register port and the register addresses.
`timescale 1ns/1ps
module grc_top #(
  parameter int LIM_EVENT_CYCLES = grc_pkg::LIM_EVENT_CYC,
  parameter int LIM_SHUT_CYCLES = grc_pkg::LIM_SHUT_CYC
) (
  input wire logic clk,
  input wire logic resetn,
  input wire grc_pkg::grc_apb_req_t apb_req,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic [grc_pkg::NPIN-1:0] pin_in,
  output logic [grc_pkg::NPIN-1:0] pin_out,
  output logic [grc_pkg::NPIN-1:0] pin_oe,
  output logic [grc_pkg::NPIN-1:0] pin_pull_select,
  output logic memory_supply_sense,
  output logic termination_reference_output,
  input wire logic supply_low,
  input wire logic slow_clock_in,
  input wire logic [grc_pkg::NPIN-1:0] seq_pin_level,
  input wire logic seq_clk_en,
  input wire logic [grc_pkg::NLDO-1:0] seq_reg_en,
  input wire logic [grc_pkg::NREG-1:0] seq_reg_sel,
  input wire logic power_down_mode,
  input wire logic reset_mode,
  input wire logic active_mode,
  input wire logic [grc_pkg::NLDO-1:0] ldo_ilim,
  input wire logic [grc_pkg::NLDO-1:0] ldo_overvolt,
  output logic system_run_request,
  output logic run_level_request,
  output logic wakeup_event,
  output logic watchdog_clear,
  output logic watchdog_hold,
  output grc_pkg::grc_reg_out_t reg_out
);
  import grc_pkg::*;

  logic [31:0] pin_cfg_q, out_sel_q, misc_q, gpi_q, prdata_d;
  logic [SET_W-1:0] set_q [NREG];
  logic [NLDO-1:0] en_q, seq_en_q;
  logic [NREG-1:0] sel_q, seq_sel_q;
  logic [EV_W-1:0] ev_q, ev_set;
  logic [ASYNC_W-1:0] s1_q, s2_q, s3_q, filt_q;
  logic [NPIN-1:0] deb_q, act_q, act_now, rise, fall, ana_mask, lvl, dig;
  logic [DEB_W-1:0] deb_cnt_q [NPIN];
  logic [CNT_W-1:0] oc_cnt_q [NLDO];
  grc_func_t func [NPIN];
  grc_out_src_t osel [NPIN];
  logic [FWD_W-1:0] fsrc [NPIN];
  logic acc, wr, rd_ok, fault_low, clk_buf_on, clk32;
  logic [NPIN-1:0] mode, pull, pol, deb_on;
  logic [NLDO-1:0] ilim, ovl;

  // ==========================================================================
  // APB slave
  assign acc = apb_req.psel & apb_req.penable & pready;
  assign wr = acc & apb_req.pwrite;

  // Zero wait states: the answer is ready in the first access cycle
  always_ff @(posedge clk) begin
    if (!resetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= apb_req.psel & ~apb_req.penable;
      prdata <= prdata_d;
      pslverr <= apb_req.psel & ~apb_req.penable & ~rd_ok;
    end
  end

  // Read mux; unmapped addresses read zero and flag an error
  always_comb begin
    prdata_d = 32'h0000_0000;
    rd_ok = 1'b1;
    if (apb_req.paddr[7:5] == SET_PAGE && apb_req.paddr[1:0] == 2'h0) begin
      prdata_d[SET_W-1:0] = set_q[apb_req.paddr[4:2]];
    end else begin
      unique case (apb_req.paddr)
        OFS_PIN_CFG: prdata_d = pin_cfg_q;
        OFS_OUT_SEL: prdata_d = out_sel_q;
        OFS_MISC: prdata_d = misc_q;
        OFS_GPI_ASSIGN: prdata_d = gpi_q;
        OFS_REG_CTRL: begin
          prdata_d[RC_EN_LSB +: NLDO] = en_q;
          prdata_d[RC_SEL_LSB +: NREG] = sel_q;
        end
        OFS_STATUS: begin
          prdata_d[ST_PIN_LSB +: NPIN] = deb_q;
          prdata_d[ST_ILIM_LSB +: NLDO] = ilim;
          prdata_d[ST_SYS_RUN] = system_run_request;
          prdata_d[ST_RUN_LVL] = run_level_request;
          prdata_d[ST_FAULT] = fault_low;
          prdata_d[ST_WD_HOLD] = watchdog_hold;
        end
        OFS_EVENT: prdata_d[EV_W-1:0] = ev_q;
        default: rd_ok = 1'b0;
      endcase
    end
  end

  // Configuration registers
  always_ff @(posedge clk) begin
    if (!resetn) begin
      pin_cfg_q <= PIN_CFG_RST;
      out_sel_q <= OUT_SEL_RST;
      misc_q <= MISC_RST;
      gpi_q <= GPI_RST;
    end else if (wr) begin
      if (apb_req.paddr == OFS_PIN_CFG) pin_cfg_q <= apb_req.pwdata;
      if (apb_req.paddr == OFS_OUT_SEL) out_sel_q <= apb_req.pwdata;
      if (apb_req.paddr == OFS_MISC) misc_q <= apb_req.pwdata;
      if (apb_req.paddr == OFS_GPI_ASSIGN) gpi_q <= apb_req.pwdata;
    end
  end

  // Settings A/B per regulator; converter entries only take writes in active mode
  always_ff @(posedge clk) begin
    for (int i = 0; i < NREG; i++) begin
      if (!resetn) begin
        set_q[i] <= SET_RST;
      end else if (wr && apb_req.paddr[7:5] == SET_PAGE && apb_req.paddr[4:2] == 3'(i)
                   && (i < NLDO || active_mode)) begin
        set_q[i] <= apb_req.pwdata[SET_W-1:0];
      end
    end
  end

  // ==========================================================================
  // Field decode
  assign mode = pin_cfg_q[PC_MODE_LSB +: NPIN];
  assign pull = pin_cfg_q[PC_PULL_LSB +: NPIN];
  assign pol = pin_cfg_q[PC_POL_LSB +: NPIN];
  assign deb_on = pin_cfg_q[PC_DEB_LSB +: NPIN];

  always_comb begin
    for (int i = 0; i < NPIN; i++) begin
      func[i] = grc_func_t'(pin_cfg_q[PC_FUNC_LSB + FN_W * i +: FN_W]);
      osel[i] = grc_out_src_t'(out_sel_q[OS_SRC_LSB + OS_W * i +: OS_W]);
      fsrc[i] = out_sel_q[OS_FWD_LSB + FWD_W * i +: FWD_W];
    end
  end

  // ==========================================================================
  // Input synchronisers: three stages, a change counts once stages two and three agree
  always_ff @(posedge clk) begin
    if (!resetn) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      filt_q <= '0;
    end else begin
      s1_q <= {ldo_overvolt, ldo_ilim, slow_clock_in, supply_low, pin_in};
      s2_q <= s1_q;
      s3_q <= s2_q;
      filt_q <= (s2_q & s3_q) | (filt_q & (s2_q ^ s3_q));
    end
  end

  assign fault_low = filt_q[NPIN];
  assign clk32 = filt_q[NPIN + 1];
  assign ilim = filt_q[NPIN + 2 +: NLDO];
  assign ovl = filt_q[NPIN + 2 + NLDO +: NLDO];

  // Analog use of pins 0 and 1 cuts their digital path in both directions
  always_comb begin
    ana_mask = '0;
    ana_mask[0] = misc_q[MI_TERM_MODE];
    ana_mask[1] = misc_q[MI_TERM_REF];
  end
  assign dig = filt_q[NPIN-1:0] & ~ana_mask;

  // ==========================================================================
  // Debounce: a level must hold for the whole window before it is taken
  always_ff @(posedge clk) begin
    for (int i = 0; i < NPIN; i++) begin
      if (!resetn) begin
        deb_q[i] <= 1'b0;
        deb_cnt_q[i] <= '0;
      end else if (!deb_on[i] || dig[i] == deb_q[i]) begin
        deb_q[i] <= dig[i];
        deb_cnt_q[i] <= '0;
      end else if (deb_cnt_q[i] == DEB_W'(DEB_CYC - 1)) begin
        deb_q[i] <= dig[i];
        deb_cnt_q[i] <= '0;
      end else begin
        deb_cnt_q[i] <= deb_cnt_q[i] + DEB_W'(1);
      end
    end
  end

  // Polarity applied after debounce; edges come from the previous active level
  assign act_now = deb_q ~^ pol;
  assign rise = act_now & ~act_q;
  assign fall = ~act_now & act_q;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      act_q <= '1; // Reset pins read as active under reset polarity; avoids a false edge
      seq_en_q <= '0;
      seq_sel_q <= '0;
    end else begin
      act_q <= act_now;
      seq_en_q <= seq_reg_en;
      seq_sel_q <= seq_reg_sel;
    end
  end

  // ==========================================================================
  // Alternate input functions (input buffer only, no event path except pin 4)
  always_ff @(posedge clk) begin
    if (!resetn) begin
      system_run_request <= 1'b0;
      run_level_request <= 1'b0;
      wakeup_event <= 1'b0;
      watchdog_clear <= 1'b0;
      watchdog_hold <= 1'b0;
    end else begin
      if (func[PIN_SYS] == FN_ALT && rise[PIN_SYS]) system_run_request <= 1'b1;
      else if (func[PIN_SYS] == FN_ALT && fall[PIN_SYS]) system_run_request <= 1'b0;
      if (func[PIN_PWR] == FN_ALT && rise[PIN_PWR]) run_level_request <= 1'b1;
      else if (func[PIN_PWR] == FN_ALT && fall[PIN_PWR]) run_level_request <= 1'b0;
      wakeup_event <= (func[PIN_SYS] == FN_ALT && rise[PIN_SYS])
                    | (func[PIN_PWR] == FN_ALT && rise[PIN_PWR] && misc_q[MI_WAKE2]);
      watchdog_clear <= func[PIN_WDK] == FN_ALT && rise[PIN_WDK];
      watchdog_hold <= func[PIN_WDK] == FN_ALT && act_now[PIN_WDK];
    end
  end

  // Input events: general inputs on active edge, system enable on assertion only
  always_comb begin
    ev_set = '0;
    for (int i = 0; i < NPIN; i++) begin
      ev_set[EV_PIN_LSB + i] = rise[i] && (func[i] == FN_IN || (i == PIN_SYS && func[i] == FN_ALT));
    end
    for (int i = 0; i < NLDO; i++) begin
      if (ilim[i] && en_q[i] && oc_cnt_q[i] == CNT_W'(LIM_EVENT_CYCLES)) ev_set[EV_LIM] = 1'b1;
    end
  end

  // Sticky events, write one to clear; a new event in the clear cycle survives
  always_ff @(posedge clk) begin
    if (!resetn) ev_q <= '0;
    else if (wr && apb_req.paddr == OFS_EVENT) ev_q <= (ev_q & ~apb_req.pwdata[EV_W-1:0]) | ev_set;
    else ev_q <= ev_q | ev_set;
  end

  // ==========================================================================
  // Pin drivers
  assign clk_buf_on = (seq_clk_en | misc_q[MI_CLK_EN]) & ~(misc_q[MI_PAUSE] & power_down_mode);

  always_comb begin
    for (int i = 0; i < NPIN; i++) begin
      unique case (osel[i])
        SRC_MODE: lvl[i] = mode[i];
        SRC_FWD: lvl[i] = FWD_PINS[i] ? deb_q[fsrc[i]] : mode[i];
        SRC_SEQ: lvl[i] = seq_pin_level[i];
        SRC_CLK: lvl[i] = clk32 & clk_buf_on;
        SRC_FAULT: lvl[i] = ~fault_low ^ mode[i];
        default: lvl[i] = mode[i];
      endcase
    end
  end

  // Open drain only ever pulls low; pull-up applies in that mode alone
  always_ff @(posedge clk) begin
    if (!resetn) begin
      pin_out <= '0;
      pin_oe <= '0;
      pin_pull_select <= '0;
      memory_supply_sense <= 1'b0;
      termination_reference_output <= 1'b0;
    end else begin
      for (int i = 0; i < NPIN; i++) begin
        pin_out[i] <= func[i] == FN_PP && !ana_mask[i] && lvl[i];
        pin_oe[i] <= !ana_mask[i] && (func[i] == FN_PP || (func[i] == FN_OD && !lvl[i]));
        pin_pull_select[i] <= !ana_mask[i] && func[i] == FN_OD && pull[i];
      end
      memory_supply_sense <= ana_mask[0];
      termination_reference_output <= ana_mask[1];
    end
  end

  // ==========================================================================
  // Over-current timing: counts continuous limit time, saturating at the shutdown count
  always_ff @(posedge clk) begin
    for (int i = 0; i < NLDO; i++) begin
      if (!resetn || !ilim[i] || !en_q[i]) oc_cnt_q[i] <= '0;
      else if (oc_cnt_q[i] != CNT_W'(LIM_SHUT_CYCLES)) oc_cnt_q[i] <= oc_cnt_q[i] + CNT_W'(1);
    end
  end

  // Enables: write, then pin or sequencer edges, then shutdown, later wins
  always_ff @(posedge clk) begin
    if (!resetn) begin
      en_q <= '0;
    end else begin
      for (int i = 0; i < NLDO; i++) begin
        logic [SRC_W-1:0] src;
        logic en_d;
        src = gpi_q[GA_EN_LSB + SRC_W * i +: SRC_W];
        en_d = en_q[i];
        if (wr && apb_req.paddr == OFS_REG_CTRL) en_d = apb_req.pwdata[RC_EN_LSB + i];
        if (src != '0) begin
          if (func[src] == FN_IN && rise[src]) en_d = 1'b1;
          if (func[src] == FN_IN && fall[src]) en_d = 1'b0;
        end else begin
          if (seq_reg_en[i] && !seq_en_q[i]) en_d = 1'b1;
          if (!seq_reg_en[i] && seq_en_q[i]) en_d = 1'b0;
        end
        if (misc_q[MI_SHUT_EN] && ilim[i] && oc_cnt_q[i] == CNT_W'(LIM_SHUT_CYCLES)) en_d = 1'b0;
        en_q[i] <= en_d;
      end
    end
  end

  // A/B selects for every regulator from software, pin edges or sequencer
  always_ff @(posedge clk) begin
    if (!resetn) begin
      sel_q <= '0;
    end else begin
      for (int i = 0; i < NREG; i++) begin
        logic [SRC_W-1:0] src;
        logic sel_d;
        src = gpi_q[GA_SEL_LSB + SRC_W * i +: SRC_W];
        sel_d = sel_q[i];
        if (wr && apb_req.paddr == OFS_REG_CTRL) sel_d = apb_req.pwdata[RC_SEL_LSB + i];
        if (src != '0) begin
          if (func[src] == FN_IN && rise[src]) sel_d = 1'b1;
          if (func[src] == FN_IN && fall[src]) sel_d = 1'b0;
        end else begin
          if (seq_reg_sel[i] && !seq_sel_q[i]) sel_d = 1'b1;
          if (!seq_reg_sel[i] && seq_sel_q[i]) sel_d = 1'b0;
        end
        sel_q[i] <= sel_d;
      end
    end
  end

  // Regulator outputs; reset mode keeps only an always-on first regulator
  always_ff @(posedge clk) begin
    if (!resetn) begin
      reg_out <= '0;
    end else begin
      for (int i = 0; i < NREG; i++) begin
        logic slp;
        slp = sel_q[i] ? set_q[i][SE_SLB] : set_q[i][SE_SLA];
        reg_out.voltage[i] <= sel_q[i] ? set_q[i][SE_VB_LSB +: V_W] : set_q[i][SE_VA_LSB +: V_W];
        if (i < NLDO) begin
          reg_out.ldo_sleep[i] <= slp;
          reg_out.ldo_discharge[i] <= ovl[i] && !set_q[i][SE_PDD];
          reg_out.ldo_enable[i] <= (en_q[i] && !reset_mode) || (i == 0 && misc_q[MI_ALWAYS_ON]);
        end else begin
          reg_out.buck_sleep[i] <= slp;
        end
      end
    end
  end

  // ==========================================================================
  // Checks
  chk_pp_mode_drive: assert property (@(posedge clk) disable iff (!resetn)
    func[3] == FN_PP && osel[3] == SRC_MODE |=> pin_oe[3] && pin_out[3] == $past(mode[3]))
    else $error("push-pull pin 3 does not follow its mode bit");
  chk_od_release: assert property (@(posedge clk) disable iff (!resetn)
    func[2] == FN_OD && osel[2] == SRC_MODE && mode[2] |=> !pin_oe[2] && pin_pull_select[2] == $past(pull[2]))
    else $error("open-drain high level not released with its pull setting");
  chk_fault_invert: assert property (@(posedge clk) disable iff (!resetn)
    func[3] == FN_PP && osel[3] == SRC_FAULT |=> pin_out[3] == ($past(fault_low) ~^ $past(mode[3])))
    else $error("supply fault output not inverted by mode bit");
  chk_clk_paused: assert property (@(posedge clk) disable iff (!resetn)
    osel[3] == SRC_CLK && misc_q[MI_PAUSE] && power_down_mode |=> !pin_out[3])
    else $error("slow clock still driven while paused in power-down");
  chk_kick_clear: assert property (@(posedge clk) disable iff (!resetn)
    func[PIN_WDK] == FN_ALT && rise[PIN_WDK] |=> watchdog_clear && watchdog_hold)
    else $error("watchdog kick edge did not clear and hold");
  chk_sys_wake: assert property (@(posedge clk) disable iff (!resetn)
    func[PIN_SYS] == FN_ALT && rise[PIN_SYS] |=> system_run_request && wakeup_event && ev_q[EV_PIN_LSB + PIN_SYS])
    else $error("system enable assertion missed request, wake or event");
  chk_limit_event: assert property (@(posedge clk) disable iff (!resetn)
    ilim[0] && en_q[0] && oc_cnt_q[0] == CNT_W'(LIM_EVENT_CYCLES) |=> ev_q[EV_LIM])
    else $error("limit event not raised after the limit time");
  chk_shut_off: assert property (@(posedge clk) disable iff (!resetn)
    misc_q[MI_SHUT_EN] && ilim[0] && oc_cnt_q[0] == CNT_W'(LIM_SHUT_CYCLES) |=> !en_q[0])
    else $error("over-current shutdown did not clear the enable");
  chk_analog_off: assert property (@(posedge clk) disable iff (!resetn)
    misc_q[MI_TERM_MODE] |=> !pin_oe[0] && !pin_out[0] && memory_supply_sense)
    else $error("analog pin 0 still driven digitally");
  chk_buck_locked: assert property (@(posedge clk) disable iff (!resetn)
    !active_mode && wr && apb_req.paddr == 8'h30 |=> set_q[NLDO] == $past(set_q[NLDO]))
    else $error("converter setting changed outside active mode");
  chk_sleep_link: assert property (@(posedge clk) disable iff (!resetn)
    sel_q[0] && set_q[0][SE_SLB] |=> reg_out.ldo_sleep[0])
    else $error("sleep link on setting B not applied");
endmodule : grc_top
